// *** pkg/mod_ctrl_pkg.sv ***
// Constants, types and carriers for the module control register writer.
// Assumes one clock domain and an AHB-Lite register bus of 32-bit words.
package mod_ctrl_pkg;

    localparam int          MEM_DEPTH     = 64;
    localparam int          MEM_AW        = 6;
    localparam logic [15:0] RACK_MIN      = 16'h0001;
    localparam logic [15:0] RACK_MAIN     = 16'h0001;
    localparam logic [15:0] RACK_MAX      = 16'h0008;
    localparam logic [15:0] SLOT_MAX_MAIN = 16'h000b;
    localparam logic [15:0] SLOT_MAX_EXT  = 16'h0007;
    localparam logic [15:0] LEN_MAX_WORD  = 16'h0100;
    localparam logic [15:0] LEN_MAX_DBL   = 16'h0080;

    localparam logic [15:0] CODE_OK       = 16'h0000;
    localparam logic [15:0] CODE_RANGE    = 16'h2003;
    localparam logic [15:0] CODE_LENGTH   = 16'h200b;
    localparam logic [15:0] CODE_AUX_ACC  = 16'h1400;
    localparam logic [15:0] CODE_IO_ACC   = 16'h1401;
    localparam logic [15:0] CODE_ARRANGE  = 16'h1402;
    localparam logic [15:0] CODE_AUX_COMM = 16'h1407;

    // Register byte addresses
    localparam logic [11:0] A_CTRL     = 12'h000;
    localparam logic [11:0] A_RACK     = 12'h004;
    localparam logic [11:0] A_SLOT     = 12'h008;
    localparam logic [11:0] A_START    = 12'h00c;
    localparam logic [11:0] A_LENGTH   = 12'h010;
    localparam logic [11:0] A_SRC_ADDR = 12'h014;
    localparam logic [11:0] A_SRC_CONST= 12'h018;
    localparam logic [11:0] A_RESULT   = 12'h01c;
    localparam logic [11:0] A_FLAGS    = 12'h020;
    localparam logic [11:0] A_ERR_CODE = 12'h024;
    localparam logic [11:0] A_IRQ_STAT = 12'h028;
    localparam logic [11:0] A_IRQ_MASK = 12'h02c;
    localparam logic [11:0] A_MEM_BASE = 12'h100;

    // Control register bits
    localparam int C_START   = 0;
    localparam int C_DOUBLE  = 1;
    localparam int C_PULSE   = 2;
    localparam int C_CONST   = 3;
    localparam int C_COUNTER = 4;
    localparam int C_CLR_ERR = 5;

    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [2:0] {
        F_NONE    = 3'b000,
        F_AUX_ACC = 3'b001,
        F_AUX_COM = 3'b010,
        F_IO_ACC  = 3'b011,
        F_ARRANGE = 3'b100
    } fault_e;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_XFER = 2'b01
    } state_e;

    typedef struct packed {
        logic        valid;
        logic [3:0]  rack;
        logic [3:0]  slot;
        logic [15:0] index;
        logic [15:0] data;
    } cr_req_s;

endpackage : mod_ctrl_pkg

// *** src/module_ctrl_reg_writer.sv ***
// Copies words from local memory or a constant into a special module's
// numbered control registers. Assumes hclk at 250 MHz, single AHB master.
//
// What this block does
// (RQ1) Rack codes 1 to 8 are accepted, 1 being the main rack.
// (RQ2) Slots 0 to 11 are accepted on the main rack and 0 to 7 elsewhere.
// (RQ3) A bad rack or slot skips the transfer, sets the flag, code 2003.
// (RQ4) A source span past the memory skips the transfer, code 2003.
// (RQ5) A length out of range skips the transfer, sets the flag, code 200b.
// (RQ6) Length is 1 to 256 single units or 1 to 128 double units.
// (RQ7) Success clears the result word; an error leaves its code there.
// (RQ8) A single unit moves one register and a double unit moves two.
// (RQ9) Two single units move the same registers as one double unit.
// (RQ10) A constant source is written into every destination register.
// (RQ11) The module holds 16-bit registers numbered from zero upward.
// (RQ12) Up to 68 modules are reachable across all racks.
// (RQ13) Auxiliary path failures report 1400 for access and 1407 for link.
// (RQ14) Module access failure reports 1401, arrangement mismatch 1402.
// (RQ15) The counter operand is allowed only with the double form.
// (RQ16) Pulse form runs once per off-to-on change of the condition; a change seen while busy (S_XFER) starts no run.
// (RQ17) Words go to ascending register numbers from the start number.
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module module_ctrl_reg_writer
    import mod_ctrl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        exec_condition,
    output cr_req_s          cr_req,
    input  wire logic        cr_ready,
    input  wire fault_e      cr_fault,
    output logic             operation_error_flag,
    output logic             busy,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        state_e                       st;
        logic                         dbl;
        logic                         pulse;
        logic                         use_const;
        logic                         counter_op;
        logic [15:0]                  rack_code;
        logic [15:0]                  slot_code;
        logic [15:0]                  start_register_number;
        logic [15:0]                  length;
        logic [15:0]                  src_addr;
        logic [31:0]                  src_const;
        logic [15:0]                  result;
        logic [15:0]                  error_code_register;
        logic                         err_flag;
        logic [1:0]                   irq_stat;
        logic [1:0]                   irq_mask;
        logic [MEM_DEPTH-1:0][15:0]   mem;
        logic [8:0]                   cnt;
        logic [8:0]                   last;
        logic                         cond_prev;
        logic                         wr_pend;
        logic [11:0]                  wr_addr;
        logic [31:0]                  rdata;
        cr_req_s                      req;
    } regs_s;

    regs_s r;
    regs_s next_r;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_mem(input logic [11:0] a);
        return a >= A_MEM_BASE &&
               a < A_MEM_BASE + 12'(MEM_DEPTH * 4);
    endfunction : is_mem

    function automatic logic [MEM_AW-1:0] mem_idx(input logic [11:0] a);
        logic [11:0] off;
        off = a - A_MEM_BASE;
        return off[MEM_AW+1:2];
    endfunction : mem_idx

    function automatic logic [15:0] fault_code(input fault_e f);
        case (f)
            F_AUX_ACC: return CODE_AUX_ACC;  // RQ13
            F_AUX_COM: return CODE_AUX_COMM; // RQ13
            F_IO_ACC:  return CODE_IO_ACC;   // RQ14
            F_ARRANGE: return CODE_ARRANGE;  // RQ14
            default:   return CODE_OK;
        endcase
    endfunction : fault_code

    // Word for transfer position k
    function automatic logic [15:0] word_at(input regs_s s,
                                            input logic [8:0] k);
        logic [15:0] a;
        a = s.src_addr + {7'h00, k};
        if (s.use_const) begin
            if (s.dbl && k[0]) begin
                return s.src_const[31:16]; // RQ10
            end
            return s.src_const[15:0]; // RQ10
        end
        return s.mem[a[MEM_AW-1:0]];
    endfunction : word_at

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic        addr_ok;
    logic        rd_take;
    logic [11:0] a_lo;
    logic        trigger;
    logic        rack_ok;
    logic        slot_ok;
    logic        len_ok;
    logic        span_ok;
    logic [16:0] words;
    logic [16:0] span_end;
    logic [15:0] code;
    logic [1:0]  ev;

    always_comb begin
        next_r   = r;
        ev       = 2'b00;
        code     = CODE_OK;
        a_lo     = haddr[11:0];
        addr_ok  = hsel && hready && htrans == HTRANS_NONSEQ;
        rd_take  = addr_ok && !hwrite;
        trigger  = 1'b0;

        // Bus write data phase
        next_r.wr_pend = addr_ok && hwrite;
        next_r.wr_addr = a_lo;
        if (r.wr_pend) begin
            case (r.wr_addr)
                A_CTRL: begin
                    next_r.dbl        = hwdata[C_DOUBLE];
                    next_r.pulse      = hwdata[C_PULSE];
                    next_r.use_const  = hwdata[C_CONST];
                    next_r.counter_op = hwdata[C_COUNTER];
                    trigger           = hwdata[C_START];
                    if (hwdata[C_CLR_ERR]) begin
                        next_r.err_flag = 1'b0;
                    end
                end
                A_RACK:      next_r.rack_code             = hwdata[15:0];
                A_SLOT:      next_r.slot_code             = hwdata[15:0];
                A_START:     next_r.start_register_number = hwdata[15:0];
                A_LENGTH:    next_r.length                = hwdata[15:0];
                A_SRC_ADDR:  next_r.src_addr              = hwdata[15:0];
                A_SRC_CONST: next_r.src_const             = hwdata;
                A_IRQ_MASK:  next_r.irq_mask              = hwdata[1:0];
                default: begin
                    if (is_mem(r.wr_addr)) begin
                        next_r.mem[mem_idx(r.wr_addr)] = hwdata[15:0];
                    end
                end
            endcase
        end

        // Bus read, sampled in the address phase
        next_r.rdata = 32'h0000_0000;
        if (rd_take) begin
            case (a_lo)
                A_CTRL:      next_r.rdata = {27'h0, r.counter_op,
                                 r.use_const, r.pulse, r.dbl, 1'b0};
                A_RACK:      next_r.rdata = {16'h0, r.rack_code};
                A_SLOT:      next_r.rdata = {16'h0, r.slot_code};
                A_START:     next_r.rdata = {16'h0, r.start_register_number};
                A_LENGTH:    next_r.rdata = {16'h0, r.length};
                A_SRC_ADDR:  next_r.rdata = {16'h0, r.src_addr};
                A_SRC_CONST: next_r.rdata = r.src_const;
                A_RESULT:    next_r.rdata = {16'h0, r.result};
                A_FLAGS:     next_r.rdata = {30'h0, r.st == S_XFER,
                                 r.err_flag};
                A_ERR_CODE:  next_r.rdata = {16'h0, r.error_code_register};
                A_IRQ_STAT: begin
                    next_r.rdata    = {30'h0, r.irq_stat};
                    next_r.irq_stat = 2'b00;
                end
                A_IRQ_MASK:  next_r.rdata = {30'h0, r.irq_mask};
                default: begin
                    if (is_mem(a_lo)) begin
                        next_r.rdata = {16'h0, r.mem[mem_idx(a_lo)]};
                    end
                end
            endcase
        end

        // Execution condition
        next_r.cond_prev = exec_condition;
        if (r.pulse) begin
            trigger = trigger || (exec_condition && !r.cond_prev); // RQ16
        end else begin
            trigger = trigger || exec_condition;
        end

        // Operand checks
        rack_ok = r.rack_code >= RACK_MIN && r.rack_code <= RACK_MAX; // RQ1
        slot_ok = (r.rack_code == RACK_MAIN) ?
                  r.slot_code <= SLOT_MAX_MAIN :               // RQ2 RQ12
                  r.slot_code <= SLOT_MAX_EXT;                  // RQ2 RQ12
        // Modes written with the start bit apply at once
        len_ok  = r.length != 16'h0000 &&
                  r.length <= (next_r.dbl ? LEN_MAX_DBL : LEN_MAX_WORD); // RQ6
        words   = next_r.dbl ? {r.length, 1'b0} : {1'b0, r.length}; // RQ8 RQ9
        span_end = 17'(r.src_addr) + words - 17'h1;
        span_ok = next_r.use_const || span_end < 17'(MEM_DEPTH);

        case (r.st)
            S_IDLE: begin
                if (trigger) begin
                    if (!rack_ok || !slot_ok) begin
                        code = CODE_RANGE; // RQ3
                    end else if (!len_ok) begin
                        code = CODE_LENGTH; // RQ5
                    end else if (!span_ok) begin
                        code = CODE_RANGE; // RQ4
                    end else if (next_r.counter_op && !next_r.dbl) begin
                        code = CODE_LENGTH; // RQ15
                    end
                    if (code != CODE_OK) begin
                        ev[IRQ_ERR] = 1'b1;
                    end else begin
                        next_r.st         = S_XFER;
                        next_r.cnt        = 9'h000;
                        next_r.last       = 9'(words - 17'h1);
                        next_r.req.valid  = 1'b1;
                        next_r.req.rack   = r.rack_code[3:0];
                        next_r.req.slot   = r.slot_code[3:0];
                        next_r.req.index  = r.start_register_number;
                        next_r.req.data   = word_at(next_r, 9'h000);
                    end
                end
            end
            S_XFER: begin
                if (cr_fault != F_NONE) begin
                    code             = fault_code(cr_fault);
                    ev[IRQ_ERR]      = 1'b1;
                    next_r.st        = S_IDLE;
                    next_r.req.valid = 1'b0;
                end else if (cr_ready) begin
                    if (r.cnt == r.last) begin
                        next_r.st        = S_IDLE;
                        next_r.req.valid = 1'b0;
                        next_r.result    = CODE_OK; // RQ7
                        ev[IRQ_DONE]     = 1'b1;
                    end else begin
                        next_r.cnt       = r.cnt + 9'h001;
                        next_r.req.index = r.req.index + 16'h0001; // RQ17
                        next_r.req.data  = word_at(r, r.cnt + 9'h001);
                    end
                end
            end
            default: begin
                next_r.st        = S_IDLE;
                next_r.req.valid = 1'b0;
            end
        endcase

        if (ev[IRQ_ERR]) begin
            next_r.result              = code; // RQ7
            next_r.error_code_register = code; // RQ3
            next_r.err_flag            = 1'b1; // RQ3
        end
        next_r.irq_stat = next_r.irq_stat | ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign hrdata               = r.rdata;
    assign cr_req               = r.req;
    assign operation_error_flag = r.err_flag;
    assign busy                 = r.st == S_XFER;
    assign irq                  = |(r.irq_stat & r.irq_mask);

endmodule : module_ctrl_reg_writer

`default_nettype wire

// *** verification/cr_partner_model.sv ***
// Behavioural special module holding 16-bit control registers.
// Assumes the writer holds each request until ready is sampled.
`timescale 1ns/1ns
`default_nettype none
module cr_partner_model
    import mod_ctrl_pkg::*;
(
    input  wire logic    hclk,
    input  wire cr_req_s cr_req,
    input  wire logic    slow,
    input  wire fault_e  fault_in,
    output logic         cr_ready,
    output fault_e       cr_fault
);
    logic [15:0] regs [0:1023];
    logic [3:0]  last_rack;
    logic        toggle = 1'b0;
    int          count = 0;
    assign cr_fault = fault_in;
    assign cr_ready = cr_req.valid && (!slow || toggle);
    always @(posedge hclk) begin
        toggle <= !toggle;
        if (cr_req.valid && cr_ready) begin
            regs[cr_req.index[9:0]] <= cr_req.data;
            last_rack <= cr_req.rack;
            count <= count + 1;
        end
    end
endmodule : cr_partner_model
`default_nettype wire

// *** verification/module_ctrl_reg_writer_props.sv ***
// Concurrent checks on the writer's ports.
// Assumes one hclk domain with active-low reset hresetn.
`timescale 1ns/1ns
`default_nettype none
module module_ctrl_reg_writer_props
    import mod_ctrl_pkg::*;
(
    input wire logic    hclk,
    input wire logic    hresetn,
    input wire cr_req_s cr_req,
    input wire logic    cr_ready,
    input wire fault_e  cr_fault,
    input wire logic    operation_error_flag,
    input wire logic    busy
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rack;
        cr_req.valid |-> cr_req.rack >= 4'h1 && cr_req.rack <= 4'h8;
    endproperty
    a_rack: assert property (p_rack) else $error("bad rack");
    property p_slot;
        cr_req.valid |-> cr_req.slot <= (cr_req.rack == 4'h1 ? 4'hb : 4'h7);
    endproperty
    a_slot: assert property (p_slot) else $error("bad slot");
    property p_hold;
        cr_req.valid && !cr_ready && cr_fault == F_NONE
            |=> cr_req.valid && $stable(cr_req);
    endproperty
    a_hold: assert property (p_hold) else $error("word dropped");
    property p_ascend;
        cr_req.valid && cr_ready ##1 cr_req.valid
            |-> cr_req.index == $past(cr_req.index) + 16'h1;
    endproperty
    a_ascend: assert property (p_ascend) else $error("index order");
    property p_skip;
        $rose(operation_error_flag) |-> !cr_req.valid;
    endproperty
    a_skip: assert property (p_skip) else $error("error moved data");
    property p_fault;
        busy && cr_fault != F_NONE |=> !cr_req.valid && operation_error_flag;
    endproperty
    a_fault: assert property (p_fault) else $error("fault kept on");
    property p_done;
        $fell(busy) |-> !cr_req.valid;
    endproperty
    a_done: assert property (p_done) else $error("word after end");
    property p_valid_busy;
        cr_req.valid |-> busy;
    endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("idle word");
endmodule : module_ctrl_reg_writer_props
bind module_ctrl_reg_writer module_ctrl_reg_writer_props u_props (
    .hclk(hclk), .hresetn(hresetn), .cr_req(cr_req), .cr_ready(cr_ready),
    .cr_fault(cr_fault), .operation_error_flag(operation_error_flag),
    .busy(busy)
);
`default_nettype wire

// *** verification/module_ctrl_reg_writer_tb_top.sv ***
// Self-checking bench for the control register writer.
// Assumes the partner model and the checker bind are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module module_ctrl_reg_writer_tb_top import mod_ctrl_pkg::*;;
    typedef struct packed {
        logic [15:0] rk, sl, st, ln, sr;
        logic [5:0]  ctl;
        logic [15:0] code;
    } row_s;
    logic        hclk, hresetn, hsel, hwrite, exec_condition, slow;
    logic        hreadyout, hresp, busy, irq, operation_error_flag, cr_ready;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic   hready;
    cr_req_s     cr_req;
    fault_e      cr_fault, fault_in;
    int          n_mismatch = 0, tests_run = 0, c0;
    fault_e      faults [4] = '{F_AUX_ACC, F_AUX_COM, F_IO_ACC, F_ARRANGE};
    logic [15:0] fcodes [4] = '{16'h1400, 16'h1407, 16'h1401, 16'h1402};
    row_s rows [17] = '{
        '{16'h1, 16'hb, 16'h5, 16'h3, 16'h0, 6'h0, 16'h0},
        '{16'h8, 16'h7, 16'h20, 16'h2, 16'ha, 6'h2, 16'h0},
        '{16'h1, 16'h0, 16'h28, 16'h2, 16'h14, 6'h0, 16'h0},
        '{16'h1, 16'h0, 16'h30, 16'h1, 16'h14, 6'h2, 16'h0},
        '{16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 6'h0, 16'h2003},
        '{16'h9, 16'h0, 16'h0, 16'h1, 16'h0, 6'h0, 16'h2003},
        '{16'h2, 16'h8, 16'h0, 16'h1, 16'h0, 6'h0, 16'h2003},
        '{16'h1, 16'hc, 16'h0, 16'h1, 16'h0, 6'h0, 16'h2003},
        '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 6'h0, 16'h200b},
        '{16'h1, 16'h0, 16'h0, 16'h101, 16'h0, 6'h8, 16'h200b},
        '{16'h1, 16'h0, 16'h0, 16'h81, 16'h0, 6'ha, 16'h200b},
        '{16'h1, 16'h0, 16'h40, 16'h100, 16'h0, 6'h8, 16'h0},
        '{16'h1, 16'h0, 16'h40, 16'h80, 16'h0, 6'ha, 16'h0},
        '{16'h1, 16'h0, 16'h0, 16'h3, 16'h3e, 6'h0, 16'h2003},
        '{16'h1, 16'h0, 16'h8, 16'h2, 16'h3e, 6'h0, 16'h0},
        '{16'h1, 16'h0, 16'h0, 16'h1, 16'h0, 6'h10, 16'h200b},
        '{16'h1, 16'h0, 16'h10, 16'h1, 16'h0, 6'h12, 16'h0}};
    assign hready = hreadyout;
    module_ctrl_reg_writer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .exec_condition(exec_condition),
        .cr_req(cr_req), .cr_ready(cr_ready), .cr_fault(cr_fault),
        .operation_error_flag(operation_error_flag), .busy(busy), .irq(irq));
    cr_partner_model far (.hclk(hclk), .cr_req(cr_req), .slow(slow),
        .fault_in(fault_in), .cr_ready(cr_ready), .cr_fault(cr_fault));
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wait_for(input logic lvl, input logic which);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((which ? busy : hready) !== lvl && n < 2000);
        if (n >= 2000) begin
            n_mismatch++;
            results();
        end
    endtask : wait_for
    task automatic bus(input logic wr, input logic [11:0] a, input int d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_for(1'b1, 1'b0);
        htrans <= 2'b00;
        hwdata <= d;
        wait_for(1'b1, 1'b0);
        q = hrdata;
    endtask : bus
    task automatic setup(input row_s r, input logic [5:0] ctl);
        bus(1'b1, A_CTRL, 32'h20);
        bus(1'b1, A_RACK, {16'h0, r.rk});
        bus(1'b1, A_SLOT, {16'h0, r.sl});
        bus(1'b1, A_START, {16'h0, r.st});
        bus(1'b1, A_LENGTH, {16'h0, r.ln});
        bus(1'b1, A_SRC_ADDR, {16'h0, r.sr});
        c0 = far.count;
        bus(1'b1, A_CTRL, {26'h0, ctl});
    endtask : setup
    function automatic logic [15:0] wexp(input row_s r, input int k);
        if (r.ctl[C_CONST])
            return (r.ctl[C_DOUBLE] && k[0]) ? 16'h5a5a : 16'hc3c3;
        return 16'ha000 + r.sr + k[15:0];
    endfunction : wexp
    task automatic check(input row_s r);
        int cnt;
        cnt = r.code != 16'h0 ? 0 : (r.ctl[C_DOUBLE] ? 2 : 1) * int'(r.ln);
        `CHK(far.count - c0, cnt)
        bus(1'b0, A_RESULT, 32'h0);
        `CHK(q[15:0], r.code)
        bus(1'b0, A_FLAGS, 32'h0);
        `CHK(q[0], r.code != 16'h0)
        bus(1'b0, A_IRQ_STAT, 32'h0);
        `CHK(q[1:0], r.code != 16'h0 ? 2'h2 : 2'h1)
        if (cnt > 0) begin
            `CHK(far.regs[r.st], wexp(r, 0))
            `CHK(far.regs[r.st + cnt - 1], wexp(r, cnt - 1))
            `CHK(far.last_rack, r.rk[3:0])
        end else begin
            bus(1'b0, A_ERR_CODE, 32'h0);
            `CHK(q[15:0], r.code)
        end
    endtask : check
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, exec_condition} = '0;
        {slow, hsize, fault_in} = {1'b0, 3'b010, F_NONE};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, 12'h300, 32'hffff);
        bus(1'b0, A_RESULT, 32'h0);
        `CHK(q, 32'h0)
        for (int i = 0; i < MEM_DEPTH; i++) begin
            bus(1'b1, A_MEM_BASE + 12'(4 * i), {16'h0, 16'ha000 + 16'(i)});
        end
        bus(1'b1, A_SRC_CONST, 32'h5a5ac3c3);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            foreach (rows[i]) begin
                setup(rows[i], rows[i].ctl | 6'h1);
                wait_for(1'b0, 1'b1);
                check(rows[i]);
            end
        end
        foreach (faults[i]) begin
            fault_in <= faults[i];
            setup(rows[0], 6'h1);
            wait_for(1'b0, 1'b1);
            fault_in <= F_NONE;
            bus(1'b0, A_RESULT, 32'h0);
            `CHK(q[15:0], fcodes[i])
        end
        setup(rows[0], 6'h4);
        exec_condition <= 1'b1;
        repeat (40) @(posedge hclk);
        `CHK(far.count - c0, 3)
        exec_condition <= 1'b0;
        bus(1'b1, A_CTRL, 32'h0);
        c0 = far.count;
        exec_condition <= 1'b1;
        repeat (40) @(posedge hclk);
        exec_condition <= 1'b0;
        wait_for(1'b0, 1'b1);
        `CHK((far.count - c0) % 3, 0)
        `CHK(far.count - c0 > 3, 1'b1)
        `CHK(irq, 1'b0)
        bus(1'b1, A_IRQ_MASK, 32'h3);
        setup(rows[4], 6'h1);
        wait_for(1'b0, 1'b1);
        @(negedge hclk);
        `CHK(irq, 1'b1)
        bus(1'b0, A_IRQ_STAT, 32'h0);
        @(negedge hclk);
        `CHK(irq, 1'b0)
        results();
    end
endmodule : module_ctrl_reg_writer_tb_top
`default_nettype wire
